// file: hw/rst_sleep_ctrl.sv
// Reset combiner, reset stretch counter and sleep power gating with an APB register slave.
// Assumes detector and pin inputs are asynchronous and a 100 MHz pclk that may stop only
// while the analog reset inputs are asserted.
//
// Function
// [RQ1] Internal reset returns all registers to initial values; execution restarts at vector.
// [RQ2] Any active source forces port reset asynchronously, without any clock; here only power-on does, the other sources pass through pclk flops.
// [RQ3] After all sources release, count fuse-selected delay before releasing reset.
// [RQ4] Exactly five sources ORed: power-on, pin, watchdog, brown-out, scan register.
// [RQ5] Reset held while supply is below power-on threshold.
// [RQ6] Pin low longer than minimum pulse causes reset; outside must hold it.
// [RQ7] Watchdog reset only when watchdog enabled and its period expires.
// [RQ8] Brown-out reset while detector enabled and supply low; never when disabled.
// [RQ9] Reset held while scan reset register is one; released when cleared.
// [RQ10] Supply rising starts counter; falling reasserts reset immediately.
// [RQ11] Enabled converter stays on in sleep; re-enable flags extended conversion.
// [RQ12] Comparator off in deep sleep; bandgap reference kept if comparator uses it.
// [RQ13] Fuse-enabled brown-out detector stays active in every sleep mode.
// [RQ14] Enabled watchdog keeps running in every sleep mode.
// [RQ15] Reference on only when detector, comparator or converter requests it.
// [RQ16] Input buffers off when I/O and converter clocks stop; wake inputs stay.
// [RQ17] Debug fuse keeps main clock running in power-down and power-save.
// [RQ18] Scan port disabled by disable bit or unprogrammed enable fuse.
// [RQ19] Enabled scan port leaves TDO undriven while not shifting.
// [RQ20] Sleep select: 000,001,010,011,110,111 modes; 100 and 101 reserved.
// [RQ21] Watchdog reset is one-cycle pulse; delay starts at its falling edge.
// [RQ22] Pin returning high runs delay counter before internal reset releases.
// [RQ23] Delay length and fuses are static inputs sampled while reset asserted.
// [RQ24] Reset asserts asynchronously and releases synchronously to pclk.
`timescale 1ns/10ps
`default_nettype none
module rst_sleep_ctrl #(
   parameter int unsigned DELAY_WIDTH = 16
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        power_ok,
   input  wire logic        reset_pin_n,
   input  wire logic        watchdog_timeout,
   input  wire logic        watchdog_enable,
   input  wire logic        brownout_detector_low,
   input  wire logic [3:0]  startup_delay_select,
   input  wire logic        brownout_enable_fuse,
   input  wire logic        debug_enable_fuse,
   input  wire logic        scan_port_enable_fuse,
   input  wire logic        scan_shifting,
   input  wire logic        scan_tdo_data,
   output logic             ports_reset_n,
   output logic             internal_reset_n,
   output logic             cpu_clock_run,
   output logic             io_clock_run,
   output logic             adc_clock_run,
   output logic             async_clock_run,
   output logic             main_osc_run,
   output logic             adc_power,
   output logic             adc_extended_conv,
   output logic             comparator_power,
   output logic             reference_power,
   output logic             brownout_power,
   output logic             watchdog_run,
   output logic             input_buffer_enable,
   output logic             wake_input_enable,
   output logic             scan_port_enable,
   output logic             tdo_out,
   output logic             tdo_oe_n
);
   if (DELAY_WIDTH < 8 || DELAY_WIDTH > 24) begin : gen_width_check
      $error("DELAY_WIDTH out of range");
   end

   // Watchdog pulse and scan reset bit are internal logic on pclk; power-on, pin and brown-out cross in.
   localparam int unsigned NUM_W = rst_sleep_pkg::NUM_SOURCES;
   logic                   pin_meta;
   logic                   pin_sync;
   logic                   bod_meta;
   logic                   bod_sync;
   logic [15:0]            pin_low_cnt;
   logic                   ext_reset;
   logic                   wdt_pulse;
   logic                   async_src_n;
   logic                   rst_meta;
   logic                   src_sync_n;
   logic [NUM_W-1:0]       src_flags;
   logic [DELAY_WIDTH-1:0] delay_cnt;
   logic [DELAY_WIDTH-1:0] delay_len;
   logic                   brownout_fuse;
   logic                   debug_fuse;
   logic                   scan_fuse;
   rst_sleep_pkg::seq_type seq;
   logic [31:0]            control;
   logic                   adc_en_prev;
   logic                   sleep_active;
   rst_sleep_pkg::sleep_type mode;

   function automatic logic [DELAY_WIDTH-1:0] delay_for(input logic [3:0] sel);
      delay_for = DELAY_WIDTH'(rst_sleep_pkg::DELAY_DEFAULT) << sel[3:2];
   endfunction : delay_for

   // Pin and brown-out level are two-flop synchronised before anything reads them.
   always_ff @(posedge pclk or negedge power_ok) begin
      if (!power_ok) begin
         pin_meta <= 1'b1;
         pin_sync <= 1'b1;
         bod_meta <= 1'b0;
         bod_sync <= 1'b0;
      end else begin
         pin_meta <= reset_pin_n;
         pin_sync <= pin_meta;
         bod_meta <= brownout_detector_low;
         bod_sync <= bod_meta;
      end
   end

   // Pulse filter: short glitches on the pin are not guaranteed to reset.
   always_ff @(posedge pclk or negedge power_ok) begin
      if (!power_ok) begin
         pin_low_cnt <= 16'h0000;
         ext_reset   <= 1'b0;
      end else if (pin_sync) begin
         pin_low_cnt <= 16'h0000;
         ext_reset   <= 1'b0;                                                   // [RQ22]
      end else if (pin_low_cnt >= 16'(rst_sleep_pkg::EXT_PULSE_CYC)) begin
         ext_reset   <= 1'b1;                                                   // [RQ6]
      end else begin
         pin_low_cnt <= pin_low_cnt + 16'h0001;
      end
   end

   // One-cycle watchdog pulse, only with the watchdog enabled.
   always_ff @(posedge pclk or negedge power_ok) begin
      if (!power_ok) begin
         wdt_pulse <= 1'b0;
      end else begin
         wdt_pulse <= watchdog_timeout && watchdog_enable && !wdt_pulse;        // [RQ7] [RQ21]
      end
   end

   // Power-on is the only truly asynchronous source; the others are clocked events.
   assign async_src_n = power_ok;                                              // [RQ5] [RQ10]

   // Combined source level: any of the four clocked sources holds reset.
   logic any_source;
   assign any_source = ext_reset || wdt_pulse || (brownout_fuse && bod_sync)   // [RQ4] [RQ8]
                       || control[rst_sleep_pkg::CTL_SCAN_RST];                 // [RQ9]

   // Port reset: asserts at once, releases on a clock edge.
   always_ff @(posedge pclk or negedge async_src_n) begin
      if (!async_src_n) begin
         rst_meta   <= 1'b0;
         src_sync_n <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         src_sync_n <= rst_meta;                                                // [RQ24]
      end
   end
   assign ports_reset_n = src_sync_n && !any_source;                            // [RQ2]

   // Fuses and delay select captured while reset is held.
   always_ff @(posedge pclk or negedge power_ok) begin
      if (!power_ok) begin
         delay_len     <= '0;
         brownout_fuse <= 1'b0;
         debug_fuse    <= 1'b0;
         scan_fuse     <= 1'b0;
      end else if (seq != rst_sleep_pkg::SEQ_RUN) begin
         delay_len     <= delay_for(startup_delay_select);                      // [RQ23]
         brownout_fuse <= brownout_enable_fuse;
         debug_fuse    <= debug_enable_fuse;
         scan_fuse     <= scan_port_enable_fuse;
      end
   end

   // Stretch sequencer; falling supply drops straight back to hold.
   always_ff @(posedge pclk or negedge async_src_n) begin
      if (!async_src_n) begin
         seq       <= rst_sleep_pkg::SEQ_HOLD;
         delay_cnt <= '0;
      end else begin
         case (seq)
            rst_sleep_pkg::SEQ_HOLD: begin
               delay_cnt <= '0;
               if (src_sync_n && !any_source) begin
                  seq <= rst_sleep_pkg::SEQ_STRETCH;                            // [RQ3] [RQ21]
               end
            end
            rst_sleep_pkg::SEQ_STRETCH: begin
               if (any_source) begin
                  seq <= rst_sleep_pkg::SEQ_HOLD;
               end else if (delay_cnt >= delay_len) begin
                  seq <= rst_sleep_pkg::SEQ_RUN;                                // [RQ3]
               end else begin
                  delay_cnt <= delay_cnt + 1'b1;
               end
            end
            rst_sleep_pkg::SEQ_RUN: begin
               if (any_source) begin
                  seq <= rst_sleep_pkg::SEQ_HOLD;
               end
            end
            default: begin
               seq <= rst_sleep_pkg::SEQ_HOLD;
            end
         endcase
      end
   end
   // Registered state only, so internal reset leaves on one clean edge.
   assign internal_reset_n = (seq == rst_sleep_pkg::SEQ_RUN);                   // [RQ1] [RQ24]

   // Source flags: set on each cause, cleared by writing zero; set wins.
   logic write_access;
   assign write_access = psel && penable && pwrite;
   always_ff @(posedge pclk or negedge power_ok) begin
      if (!power_ok) begin
         src_flags <= NUM_W'(1);
      end else begin
         for (int i = 0; i < NUM_W; i++) begin
            if (write_access && paddr == rst_sleep_pkg::ADDR_STATUS && !pwdata[i]) begin
               src_flags[i] <= 1'b0;
            end
         end
         if (ext_reset) begin
            src_flags[rst_sleep_pkg::SRC_EXT] <= 1'b1;
         end
         if (brownout_fuse && bod_sync) begin
            src_flags[rst_sleep_pkg::SRC_BOD] <= 1'b1;
         end
         if (wdt_pulse) begin
            src_flags[rst_sleep_pkg::SRC_WDT] <= 1'b1;
         end
         if (control[rst_sleep_pkg::CTL_SCAN_RST]) begin
            src_flags[rst_sleep_pkg::SRC_SCAN] <= 1'b1;
         end
      end
   end

   // Control register; scan reset bit survives internal reset so it can hold it.
   always_ff @(posedge pclk or negedge async_src_n) begin
      if (!async_src_n) begin
         control <= rst_sleep_pkg::CONTROL_RESET;
      end else if (write_access && paddr == rst_sleep_pkg::ADDR_CONTROL) begin
         control <= {23'h000000, pwdata[8:0]};
      end else if (!internal_reset_n) begin
         control <= rst_sleep_pkg::CONTROL_RESET
                    | (control & (32'h1 << rst_sleep_pkg::CTL_SCAN_RST));       // [RQ1]
      end
   end

   // APB read and error: single-cycle answer, unmapped addresses error.
   logic addr_hit;
   assign addr_hit = (paddr == rst_sleep_pkg::ADDR_CONTROL) || (paddr == rst_sleep_pkg::ADDR_STATUS)
                     || (paddr == rst_sleep_pkg::ADDR_POWER) || (paddr == rst_sleep_pkg::ADDR_DELAY);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_hit;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         if (paddr == rst_sleep_pkg::ADDR_CONTROL) begin
            prdata <= control;
         end else if (paddr == rst_sleep_pkg::ADDR_STATUS) begin
            prdata <= {27'h0000000, src_flags};
         end else if (paddr == rst_sleep_pkg::ADDR_POWER) begin
            prdata <= {19'h00000, main_osc_run, input_buffer_enable, reference_power,
                       comparator_power, adc_power, adc_extended_conv, brownout_power,
                       watchdog_run, scan_port_enable, io_clock_run, adc_clock_run,
                       async_clock_run, cpu_clock_run};
         end else if (paddr == rst_sleep_pkg::ADDR_DELAY) begin
            prdata <= 32'(delay_len);
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // Sleep decode; reserved codes leave the device awake.
   assign mode = rst_sleep_pkg::sleep_type'(control[rst_sleep_pkg::CTL_SLEEP_LSB +: 3]);
   always_comb begin
      sleep_active    = control[rst_sleep_pkg::CTL_SLEEP_REQ] && internal_reset_n;
      cpu_clock_run   = 1'b1;
      io_clock_run    = 1'b1;
      adc_clock_run   = 1'b1;
      async_clock_run = 1'b1;
      main_osc_run    = 1'b1;
      if (sleep_active) begin
         case (mode)                                                            // [RQ20]
            rst_sleep_pkg::SLEEP_IDLE: begin
               cpu_clock_run = 1'b0;
            end
            rst_sleep_pkg::SLEEP_ADC_NR: begin
               cpu_clock_run = 1'b0;
               io_clock_run  = 1'b0;
            end
            rst_sleep_pkg::SLEEP_PWR_DOWN, rst_sleep_pkg::SLEEP_STANDBY: begin
               cpu_clock_run   = 1'b0;
               io_clock_run    = 1'b0;
               adc_clock_run   = 1'b0;
               async_clock_run = 1'b0;
               main_osc_run    = (mode == rst_sleep_pkg::SLEEP_STANDBY) || debug_fuse; // [RQ17]
            end
            rst_sleep_pkg::SLEEP_PWR_SAVE, rst_sleep_pkg::SLEEP_EXT_STBY: begin
               cpu_clock_run = 1'b0;
               io_clock_run  = 1'b0;
               adc_clock_run = 1'b0;
               main_osc_run  = (mode == rst_sleep_pkg::SLEEP_EXT_STBY) || debug_fuse; // [RQ17]
            end
            default: begin
               cpu_clock_run = 1'b1;
            end
         endcase
      end
   end

   // Power gating of analog blocks.
   logic cmp_on;
   assign cmp_on = control[rst_sleep_pkg::CTL_CMP_EN] && (!sleep_active
                   || mode == rst_sleep_pkg::SLEEP_IDLE || mode == rst_sleep_pkg::SLEEP_ADC_NR); // [RQ12]
   assign comparator_power    = cmp_on;
   assign adc_power           = control[rst_sleep_pkg::CTL_ADC_EN];             // [RQ11]
   assign brownout_power      = brownout_fuse;                                  // [RQ13]
   assign watchdog_run        = watchdog_enable;                                // [RQ14]
   assign reference_power     = brownout_fuse || adc_power
                                || (control[rst_sleep_pkg::CTL_CMP_EN]
                                    && control[rst_sleep_pkg::CTL_CMP_BG]); // [RQ15]
   assign input_buffer_enable = io_clock_run || adc_clock_run;                  // [RQ16]
   assign wake_input_enable   = 1'b1;                                           // [RQ16]

   // Converter re-enable marks the next conversion as extended.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_en_prev       <= 1'b0;
         adc_extended_conv <= 1'b1;
      end else begin
         adc_en_prev <= adc_power;
         if (!adc_power) begin
            adc_extended_conv <= 1'b1;                                          // [RQ11]
         end else if (adc_en_prev) begin
            adc_extended_conv <= 1'b0;
         end
      end
   end

   // Scan port enable and TDO drive.
   assign scan_port_enable = scan_fuse && !control[rst_sleep_pkg::CTL_SCAN_DIS]; // [RQ18]
   assign tdo_out          = scan_tdo_data;
   assign tdo_oe_n         = !(scan_port_enable && scan_shifting);              // [RQ19]
endmodule : rst_sleep_ctrl
`default_nettype wire

// file: hw/rst_sleep_pkg.sv
// Package: constants for the reset and sleep power control block.
// Assumes a 100 MHz pclk; the minimum pin pulse count derives from it.
package rst_sleep_pkg;
   localparam int unsigned CLK_MHZ           = 100;
   // Minimum pin pulse in ns and cycles, rounded up
   localparam int unsigned EXT_PULSE_NS      = 1500;
   localparam int unsigned EXT_PULSE_CYC     = (EXT_PULSE_NS * CLK_MHZ + 999) / 1000;
   // Register byte addresses
   localparam logic [11:0] ADDR_CONTROL      = 12'h000;
   localparam logic [11:0] ADDR_STATUS       = 12'h004;
   localparam logic [11:0] ADDR_POWER        = 12'h008;
   localparam logic [11:0] ADDR_DELAY        = 12'h00c;
   // Control register fields
   localparam int unsigned CTL_SLEEP_LSB     = 0;
   localparam int unsigned CTL_SLEEP_REQ     = 3;
   localparam int unsigned CTL_SCAN_DIS      = 4;
   localparam int unsigned CTL_SCAN_RST      = 5;
   localparam int unsigned CTL_ADC_EN        = 6;
   localparam int unsigned CTL_CMP_EN        = 7;
   localparam int unsigned CTL_CMP_BG        = 8;
   localparam logic [31:0] CONTROL_RESET     = 32'h0000_0000;
   // Reset source bits of the status register
   localparam int unsigned SRC_POR           = 0;
   localparam int unsigned SRC_EXT           = 1;
   localparam int unsigned SRC_BOD           = 2;
   localparam int unsigned SRC_WDT           = 3;
   localparam int unsigned SRC_SCAN          = 4;
   localparam int unsigned NUM_SOURCES       = 5;
   // Base stretch length
   localparam int unsigned DELAY_DEFAULT     = 16;
   typedef enum logic [2:0] {
      SLEEP_IDLE     = 3'b000,
      SLEEP_ADC_NR   = 3'b001,
      SLEEP_PWR_DOWN = 3'b010,
      SLEEP_PWR_SAVE = 3'b011,
      SLEEP_RSVD_4   = 3'b100,
      SLEEP_RSVD_5   = 3'b101,
      SLEEP_STANDBY  = 3'b110,
      SLEEP_EXT_STBY = 3'b111
   } sleep_type;
   typedef enum logic [1:0] {
      SEQ_HOLD    = 2'b00,
      SEQ_STRETCH = 2'b01,
      SEQ_RUN     = 2'b10
   } seq_type;
endpackage : rst_sleep_pkg

// file: verification/far_side_model.sv
// Far-side model: supply detectors, reset pin, watchdog and scan port status.
// Assumes the bench calls its tasks and sets its levels from the pclk domain.
`timescale 1ns/10ps
`default_nettype none
module far_side_model (
   input  wire logic pclk,
   output logic      power_ok,
   output logic      reset_pin_n,
   output logic      watchdog_timeout,
   output logic      watchdog_enable,
   output logic      brownout_detector_low,
   output logic      scan_shifting,
   output logic      scan_tdo_data
);
   initial begin
      power_ok              = 1'b0;
      reset_pin_n           = 1'b1;
      watchdog_timeout      = 1'b0;
      watchdog_enable       = 1'b0;
      brownout_detector_low = 1'b0;
      scan_shifting         = 1'b0;
      scan_tdo_data         = 1'b0;
   end
   // Toggles every cycle so a stale value never passes for driven data
   always @(posedge pclk) scan_tdo_data <= ~scan_tdo_data;
   // Pin held low well past the minimum pulse so a reset is guaranteed
   task pin_pulse(input int cycles);
      @(posedge pclk);
      reset_pin_n <= 1'b0;
      repeat (cycles) @(posedge pclk);
      reset_pin_n <= 1'b1;
   endtask : pin_pulse
   task wdt_pulse(input logic en);
      @(posedge pclk);
      watchdog_enable  <= en;
      watchdog_timeout <= 1'b1;
      @(posedge pclk);
      watchdog_timeout <= 1'b0;
   endtask : wdt_pulse
endmodule : far_side_model
`default_nettype wire

// file: verification/rst_sleep_ctrl_props.sv
// Checker: reset combining, stretch length and sleep gating at the ports.
// Assumes fuses and delay select change only while reset is held.
`timescale 1ns/10ps
`default_nettype none
module rst_sleep_ctrl_props (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       power_ok,
   input wire logic       reset_pin_n,
   input wire logic       watchdog_timeout,
   input wire logic       watchdog_enable,
   input wire logic       brownout_detector_low,
   input wire logic [3:0] startup_delay_select,
   input wire logic       brownout_enable_fuse,
   input wire logic       scan_port_enable_fuse,
   input wire logic       scan_shifting,
   input wire logic       ports_reset_n,
   input wire logic       internal_reset_n,
   input wire logic       io_clock_run,
   input wire logic       adc_clock_run,
   input wire logic       adc_power,
   input wire logic       reference_power,
   input wire logic       brownout_power,
   input wire logic       watchdog_run,
   input wire logic       input_buffer_enable,
   input wire logic       wake_input_enable,
   input wire logic       scan_port_enable,
   input wire logic       tdo_oe_n
);
   logic [31:0] quiet_cnt;
   logic [31:0] dly;
   assign dly = 32'h10 << startup_delay_select[3:2];
   // Edges since the analog and pin sources went quiet; saturates to avoid wrap
   always_ff @(posedge pclk) begin
      if (!power_ok || !reset_pin_n || (brownout_enable_fuse && brownout_detector_low))
         quiet_cnt <= 32'h0;
      else if (quiet_cnt != 32'hffff_ffff)
         quiet_cnt <= quiet_cnt + 32'h1;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence wdt_fire;
      watchdog_enable && watchdog_timeout && internal_reset_n;
   endsequence
   por_hold_a: assert property (!power_ok |-> !ports_reset_n && !internal_reset_n)
      else $error("reset not held while supply low");
   stretch_len_a: assert property ($rose(internal_reset_n) |-> quiet_cnt >= dly)
      else $error("internal reset released before the delay");
   bod_reset_a: assert property (brownout_enable_fuse && brownout_detector_low |-> ##[0:3] !ports_reset_n)
      else $error("brown-out did not reset");
   wdt_reset_a: assert property (wdt_fire |-> ##[0:4] !internal_reset_n)
      else $error("watchdog timeout did not reset");
   bod_sleep_a: assert property (internal_reset_n && brownout_enable_fuse |-> brownout_power)
      else $error("brown-out detector gated off");
   wdt_sleep_a: assert property (watchdog_enable |-> watchdog_run)
      else $error("watchdog gated off");
   buf_gate_a: assert property (internal_reset_n |->
      input_buffer_enable == (io_clock_run || adc_clock_run) && wake_input_enable)
      else $error("input buffer gating wrong");
   ref_need_a: assert property (brownout_power || adc_power |-> reference_power)
      else $error("reference off while requested");
   tdo_float_a: assert property (scan_port_enable && !scan_shifting |-> tdo_oe_n)
      else $error("data out driven while not shifting");
   scan_fuse_a: assert property (internal_reset_n && !scan_port_enable_fuse |-> !scan_port_enable)
      else $error("scan port enabled with fuse off");
endmodule : rst_sleep_ctrl_props
bind rst_sleep_ctrl rst_sleep_ctrl_props props_i (.*);
`default_nettype wire

// file: verification/rst_sleep_ctrl_tb.sv
// Testbench: drives reset sources, fuses and APB; checks reset and sleep gating.
// Assumes the far-side model supplies detector, pin, watchdog and scan levels.
`timescale 1ns/10ps
`default_nettype none
module rst_sleep_ctrl_tb;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  dsel;
   logic        bod_fuse;
   logic        dbg_fuse;
   logic        scan_fuse;
   logic [31:0] rd;
   logic        er;
   logic [31:0] dly;
   int          failures;
   int          n_tests;
   int          n;
   wire logic [31:0] prdata;
   wire logic async_clock_run, cpu_clock_run;
   wire logic pready, pslverr, power_ok, reset_pin_n, watchdog_timeout, watchdog_enable;
   wire logic brownout_detector_low, scan_shifting, scan_tdo_data, ports_reset_n;
   wire logic internal_reset_n, io_clock_run, adc_clock_run, main_osc_run, adc_power;
   wire logic adc_extended_conv, comparator_power, reference_power, brownout_power;
   wire logic watchdog_run, input_buffer_enable, wake_input_enable, scan_port_enable, tdo_oe_n;
   far_side_model far (.*);
   rst_sleep_ctrl uut (.*, .startup_delay_select(dsel), .brownout_enable_fuse(bod_fuse),
      .debug_enable_fuse(dbg_fuse), .scan_port_enable_fuse(scan_fuse), .tdo_out());
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask : apb
   // Counts from the source's release, with a short grace for synchronised sources to take hold
   task rel;
      n = 0;
      while ((n < 4 || internal_reset_n !== 1'b1) && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      check({31'h0, n >= dly && n < 3000}, 32'h1);
   endtask : rel
   task power_up(input logic [3:0] s, input logic f);
      @(posedge pclk);
      far.power_ok <= 1'b0;
      dsel         <= s;
      bod_fuse     <= f;
      dbg_fuse     <= f;
      scan_fuse    <= f;
      dly = 32'h10 << s[3:2];
      @(negedge pclk);
      check({ports_reset_n, internal_reset_n}, 32'h0);
      repeat (5) @(posedge pclk);
      far.power_ok <= 1'b1;
      rel;
      apb(1'b0, rst_sleep_pkg::ADDR_DELAY, 32'h0);
      check(rd, dly);
   endtask : power_up
   task sleep_scan(input logic dbg);
      logic io;
      logic ad;
      for (int c = 0; c < 8; c++) begin
         io = (c == 0 || c == 4 || c == 5);
         ad = (c <= 1 || c == 4 || c == 5);
         apb(1'b1, rst_sleep_pkg::ADDR_CONTROL, 32'h0c8 | c);
         check({cpu_clock_run, io_clock_run, adc_clock_run, async_clock_run},
               {c[2] & ~c[1], io, ad, c != 2 && c != 6});
         check({input_buffer_enable, wake_input_enable}, {io | ad, 1'b1});
         if (c < 4 || c > 5)
            check(comparator_power, ad);
         check({adc_power, reference_power}, 32'h3);
         check(main_osc_run, dbg || (c != 2 && c != 3));
         check({watchdog_run, brownout_power}, {1'b1, bod_fuse});
      end
   endtask : sleep_scan
   initial begin
      #300000;
      failures++;
      stop_test;
   end
   initial begin
      failures = 0;
      n_tests  = 0;
      presetn  = 1'b0;
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = 12'h000;
      pwdata   = 32'h0;
      dsel     = 4'h0;
      bod_fuse = 1'b0;
      dbg_fuse = 1'b0;
      scan_fuse = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      power_up(4'h0, 1'b0);
      check(scan_port_enable, 1'b0);
      apb(1'b1, rst_sleep_pkg::ADDR_CONTROL, 32'h0);
      check(reference_power, 1'b0);
      apb(1'b1, rst_sleep_pkg::ADDR_CONTROL, 32'h18a);
      check({comparator_power, reference_power}, 32'h1);
      far.brownout_detector_low <= 1'b1;
      repeat (6) @(posedge pclk);
      check(internal_reset_n, 1'b1);
      far.brownout_detector_low <= 1'b0;
      far.wdt_pulse(1'b0);
      repeat (6) @(posedge pclk);
      check(internal_reset_n, 1'b1);
      far.wdt_pulse(1'b1);
      rel;
      far.pin_pulse(160);
      rel;
      apb(1'b1, rst_sleep_pkg::ADDR_CONTROL, 32'h20);
      repeat (4) @(posedge pclk);
      check(internal_reset_n, 1'b0);
      apb(1'b1, rst_sleep_pkg::ADDR_CONTROL, 32'h0);
      rel;
      apb(1'b1, rst_sleep_pkg::ADDR_CONTROL, 32'h40);
      apb(1'b1, rst_sleep_pkg::ADDR_CONTROL, 32'h0);
      apb(1'b1, rst_sleep_pkg::ADDR_CONTROL, 32'h40);
      @(negedge pclk);
      check(adc_extended_conv, 1'b1);
      sleep_scan(1'b0);
      power_up(4'h4, 1'b1);
      check({scan_port_enable, tdo_oe_n}, 32'h3);
      far.scan_shifting <= 1'b1;
      @(negedge pclk);
      check(tdo_oe_n, 1'b0);
      apb(1'b1, rst_sleep_pkg::ADDR_CONTROL, 32'h10);
      check(scan_port_enable, 1'b0);
      far.brownout_detector_low <= 1'b1;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      check(ports_reset_n, 1'b0);
      repeat (4) @(posedge pclk);
      far.brownout_detector_low <= 1'b0;
      rel;
      sleep_scan(1'b1);
      apb(1'b0, 12'h010, 32'h0);
      check({er, rd[30:0]}, 32'h8000_0000);
      stop_test;
   end
endmodule : rst_sleep_ctrl_tb
`default_nettype wire
